//--- logic/mfrt_defs.svh
// Purpose: shared constants of the flash reset timing link
// Assumes: 100 MHz core clock on both ends
// Notes:   times in ns, counts derived in the modules
`ifndef MFRT_DEFS_SVH
`define MFRT_DEFS_SVH
`define MFRT_CLK_NS          10
`define MFRT_RST_LOW_NS      1000
`define MFRT_RST_HIGH_NS     1000
`define MFRT_RST_CMD_NS      200000
`define MFRT_PREAMBLE_CYC    74
`define MFRT_LCLK_HALF       6
`define MFRT_ARG_BOOT        32'h0FFFFFFA
`define MFRT_ARG_ZERO        32'h00000000
`define MFRT_CMD_RESET       6'h00
`define MFRT_CMD_OPCOND      6'h01
`define MFRT_CMD_SWITCH      6'h06
`define MFRT_CMD_WP_STATUS   6'h1E
`define MFRT_CMD_WP_TYPE     6'h1F
`define MFRT_INIT_MAX        16
`define MFRT_WP_GAP_CYC      1000
`define MFRT_BOOT_CYC        64
`define MFRT_DEV_INIT_CYC    32
`define MFRT_PRELOAD_DEF     32'h00100000
`endif

//--- logic/mfrt_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes:   binary state codes written out
`default_nettype none
package mfrt_pkg;
    typedef enum logic [1:0] {
        H_RST_LOW  = 2'b00,
        H_RST_WAIT = 2'b01,
        H_READY    = 2'b10
    } mfrt_host_st_t;
    typedef enum logic [1:0] {
        D_BOOT  = 2'b00,
        D_RESET = 2'b01,
        D_INIT  = 2'b10,
        D_RUN   = 2'b11
    } mfrt_dev_st_t;
endpackage : mfrt_pkg
`default_nettype wire

//--- logic/mfrt_link_if.sv
// Purpose: pins between host controller and flash device
// Assumes: each side syncs the single-bit pins it receives
// Notes:   command words held stable until the ack toggle returns
`default_nettype none
interface mfrt_link_if;
    logic        rst_n_pin;  // hardware reset, active low
    logic        clk_pin;    // bus clock from host divider
    logic        cmd_tgl;    // flips once per command
    logic [5:0]  cmd_idx;    // command index
    logic [31:0] cmd_arg;    // command argument
    logic        ack_tgl;    // device echo of cmd_tgl
    modport host (output rst_n_pin, output clk_pin, output cmd_tgl,
                  output cmd_idx, output cmd_arg, input ack_tgl);
    modport dev  (input rst_n_pin, input clk_pin, input cmd_tgl,
                  input cmd_idx, input cmd_arg, output ack_tgl);
endinterface : mfrt_link_if
`default_nettype wire

//--- logic/mfrt_host.sv
// Purpose: host end; drives reset pin, bus clock and commands
// Assumes: user pulses are one cycle, on clk
// Notes:   refused requests are dropped and flagged for one cycle
// Summary of operation
// R1 - reset low and high each at least 1 us
// R2 - wait 200 us after release before commands
// R3 - 74 clocks before opcond or boot reset
// R4 - device may ignore reset pin after power-on
// R5 - device caps preload at reported limit
// R6 - device updates limit on enhanced partition
// R7 - limit repeated reset and init iterations
// R8 - each opcond costs one raw array read
// R9 - space out write-protect queries
// R10 - device starts reset on pin rising edge
`include "mfrt_defs.svh"
`default_nettype none
module mfrt_host #(
    parameter int unsigned RST_CMD_CYC = (`MFRT_RST_CMD_NS + `MFRT_CLK_NS - 1) / `MFRT_CLK_NS,
    parameter int unsigned INIT_MAX    = `MFRT_INIT_MAX,
    parameter int unsigned WP_GAP_CYC  = `MFRT_WP_GAP_CYC
) (
    input  wire logic        clk,          // core clock
    input  wire logic        arst_n,       // async reset, active low
    mfrt_link_if.host        link,         // pins to device
    input  wire logic        rst_req,      // pulse: hardware reset
    input  wire logic        cmd_req,      // pulse: send command
    input  wire logic [5:0]  cmd_idx,      // command index
    input  wire logic [31:0] cmd_arg,      // command argument
    output var  logic        cmd_ready,    // level: command may go
    output var  logic        cmd_sent,     // pulse: command issued
    output var  logic        cmd_refused,  // pulse: command dropped
    output var  logic        rst_refused,  // pulse: reset dropped
    output var  logic        link_up       // level: ready for commands
);
    import mfrt_pkg::*;

    localparam int unsigned LOW_CYC  = (`MFRT_RST_LOW_NS + `MFRT_CLK_NS - 1) / `MFRT_CLK_NS;
    localparam int unsigned HIGH_CYC = (`MFRT_RST_HIGH_NS + `MFRT_CLK_NS - 1) / `MFRT_CLK_NS;

    mfrt_host_st_t st_ff;
    logic [15:0]   cnt_ff;
    logic [3:0]    div_ff;
    logic          lclk_ff;
    logic [6:0]    pre_ff;
    logic [7:0]    init_ff;
    logic [15:0]   wp_ff;
    logic          tgl_ff;
    logic [5:0]    idx_ff;
    logic [31:0]   arg_ff;
    logic          ack_s1_ff;
    logic          ack_s2_ff;
    logic          sent_ff;
    logic          cref_ff;
    logic          rref_ff;
    logic          lclk_rise;
    logic          rst_take;
    logic          is_init;
    logic          needs_pre;
    logic          is_wp;
    logic          allowed;
    logic          cmd_take;

    // bus clock divider; runs free so the preamble can build up
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_ff  <= 4'h0;
            lclk_ff <= 1'b0;
        end
        else if (div_ff == 4'(`MFRT_LCLK_HALF - 1))
        begin
            div_ff  <= 4'h0;
            lclk_ff <= ~lclk_ff;
        end
        else
        begin
            div_ff <= div_ff + 4'h1;
        end
    end
    assign lclk_rise = (div_ff == 4'(`MFRT_LCLK_HALF - 1)) && !lclk_ff;

    // preamble count restarts with every reset pulse
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pre_ff <= 7'h00;
        else if (st_ff == H_RST_LOW)
            pre_ff <= 7'h00;
        else if (lclk_rise && pre_ff != 7'(`MFRT_PREAMBLE_CYC))
            pre_ff <= pre_ff + 7'h01; // R3
    end

    // a second pulse only after the high interval has passed
    assign rst_take = rst_req && ((st_ff == H_READY) ||
                      (st_ff == H_RST_WAIT && cnt_ff >= 16'(HIGH_CYC - 1))); // R1

    // reset sequence; power-on starts with the pin held low
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff  <= H_RST_LOW;
            cnt_ff <= 16'h0000;
        end
        else
        begin
            unique case (st_ff)
                H_RST_LOW:
                begin
                    if (cnt_ff >= 16'(LOW_CYC - 1)) // R1
                    begin
                        st_ff  <= H_RST_WAIT;
                        cnt_ff <= 16'h0000;
                    end
                    else
                        cnt_ff <= cnt_ff + 16'h0001;
                end
                H_RST_WAIT:
                begin
                    if (rst_take)
                    begin
                        st_ff  <= H_RST_LOW;
                        cnt_ff <= 16'h0000;
                    end
                    else if (cnt_ff >= 16'(RST_CMD_CYC - 1)) // R2
                        st_ff <= H_READY;
                    else
                        cnt_ff <= cnt_ff + 16'h0001;
                end
                H_READY:
                begin
                    if (rst_take)
                    begin
                        st_ff  <= H_RST_LOW;
                        cnt_ff <= 16'h0000;
                    end
                end
                default:
                    st_ff <= H_RST_LOW;
            endcase
        end
    end

    // ack from the device comes from another domain
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end
        else
        begin
            ack_s1_ff <= link.ack_tgl;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    // command gating
    assign is_init   = (cmd_idx == `MFRT_CMD_RESET) || (cmd_idx == `MFRT_CMD_OPCOND);
    assign needs_pre = (cmd_idx == `MFRT_CMD_OPCOND) ||
                       (cmd_idx == `MFRT_CMD_RESET && cmd_arg == `MFRT_ARG_BOOT);
    assign is_wp     = (cmd_idx == `MFRT_CMD_WP_STATUS) || (cmd_idx == `MFRT_CMD_WP_TYPE);
    assign allowed   = !(needs_pre && pre_ff != 7'(`MFRT_PREAMBLE_CYC)) // R3
                    && !(is_init && init_ff >= 8'(INIT_MAX)) // R7
                    && !(is_wp && wp_ff != 16'h0000); // R9
    assign cmd_ready = (st_ff == H_READY) && (tgl_ff == ack_s2_ff) && !rst_req; // R2
    assign cmd_take  = cmd_req && cmd_ready && allowed;

    // launch: words are set with the toggle and held until acked
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tgl_ff <= 1'b0;
            idx_ff <= 6'h00;
            arg_ff <= 32'h00000000;
        end
        else if (cmd_take)
        begin
            tgl_ff <= ~tgl_ff;
            idx_ff <= cmd_idx;
            arg_ff <= cmd_arg;
        end
    end

    // iteration counter kept since power-on, never cleared by resets
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            init_ff <= 8'h00;
        else if (((cmd_take && is_init) || rst_take) && init_ff != 8'hFF)
            init_ff <= init_ff + 8'h01; // R7
    end

    // query spacing; tight polling would wear the array
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wp_ff <= 16'h0000;
        else if (cmd_take && is_wp)
            wp_ff <= 16'(WP_GAP_CYC); // R9
        else if (wp_ff != 16'h0000)
            wp_ff <= wp_ff - 16'h0001;
    end

    // status pulses
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sent_ff <= 1'b0;
            cref_ff <= 1'b0;
            rref_ff <= 1'b0;
        end
        else
        begin
            sent_ff <= cmd_take;
            cref_ff <= cmd_req && !cmd_take;
            rref_ff <= rst_req && !rst_take;
        end
    end

    assign cmd_sent       = sent_ff;
    assign cmd_refused    = cref_ff;
    assign rst_refused    = rref_ff;
    assign link_up        = (st_ff == H_READY);
    assign link.rst_n_pin = (st_ff != H_RST_LOW); // R1
    assign link.clk_pin   = lclk_ff;
    assign link.cmd_tgl   = tgl_ff;
    assign link.cmd_idx   = idx_ff;
    assign link.cmd_arg   = arg_ff;
endmodule : mfrt_host
`default_nettype wire

//--- logic/mfrt_dev.sv
// Purpose: device end; reset pin handling, command intake, preload cap
// Assumes: host holds command words until the ack toggle returns
// Notes:   pin enable is caught once at the end of boot
`include "mfrt_defs.svh"
`default_nettype none
module mfrt_dev #(
    parameter int unsigned BOOT_CYC = `MFRT_BOOT_CYC,
    parameter int unsigned INIT_CYC = `MFRT_DEV_INIT_CYC
) (
    input  wire logic        clk,          // core clock
    input  wire logic        arst_n,       // async reset, active low
    mfrt_link_if.dev         link,         // pins from host
    input  wire logic        rst_pin_en,   // config: honour reset pin
    input  wire logic [31:0] enh_limit,    // limit after partition set
    input  wire logic        pre_req,      // pulse: preload request
    input  wire logic [31:0] pre_len,      // requested preload bytes
    output var  logic [31:0] pre_grant,    // granted preload bytes
    output var  logic        pre_done,     // pulse: grant valid
    output var  logic        pre_capped,   // level: last grant capped
    output var  logic [31:0] pre_limit,    // reported preload limit
    output var  logic        cmd_valid,    // pulse: command taken
    output var  logic [5:0]  cmd_index,    // taken index
    output var  logic [31:0] cmd_arg,      // taken argument
    output var  logic        nand_read,    // pulse: raw array read
    output var  logic [31:0] read_count,   // raw reads so far
    output var  logic        dev_ready,    // level: running
    output var  logic        preamble_ok   // level: 74 clocks seen
);
    import mfrt_pkg::*;

    mfrt_dev_st_t st_ff;
    logic [15:0]  cnt_ff;
    logic         en_ff;
    logic [2:0]   rst_sy_ff;
    logic [2:0]   clk_sy_ff;
    logic [2:0]   tgl_sy_ff;
    logic         ack_ff;
    logic         vld_ff;
    logic [5:0]   idx_ff;
    logic [31:0]  arg_ff;
    logic         rd_ff;
    logic [31:0]  rdc_ff;
    logic [31:0]  lim_ff;
    logic [31:0]  grant_ff;
    logic         done_ff;
    logic         cap_ff;
    logic [6:0]   pre_ff;
    logic         rst_rise;
    logic         new_cmd;
    logic         take;

    // pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sy_ff <= 3'h0;
            clk_sy_ff <= 3'h0;
            tgl_sy_ff <= 3'h0;
        end
        else
        begin
            rst_sy_ff <= {rst_sy_ff[1:0], link.rst_n_pin};
            clk_sy_ff <= {clk_sy_ff[1:0], link.clk_pin};
            tgl_sy_ff <= {tgl_sy_ff[1:0], link.cmd_tgl};
        end
    end
    assign rst_rise = rst_sy_ff[1] && !rst_sy_ff[2];
    assign new_cmd  = tgl_sy_ff[1] ^ tgl_sy_ff[2];
    assign take     = new_cmd && (st_ff == D_RUN);

    // boot ignores the pin until the enable is loaded
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff  <= D_BOOT;
            cnt_ff <= 16'h0000;
            en_ff  <= 1'b0;
        end
        else
        begin
            unique case (st_ff)
                D_BOOT:
                begin
                    if (cnt_ff >= 16'(BOOT_CYC - 1))
                    begin
                        en_ff <= rst_pin_en; // R4
                        st_ff <= D_RUN;
                    end
                    else
                        cnt_ff <= cnt_ff + 16'h0001; // R4
                end
                D_RESET:
                begin
                    cnt_ff <= 16'h0000;
                    if (rst_rise)
                        st_ff <= D_INIT; // R10
                end
                D_INIT:
                begin
                    if (en_ff && !rst_sy_ff[1])
                        st_ff <= D_RESET;
                    else if (cnt_ff >= 16'(INIT_CYC - 1))
                        st_ff <= D_RUN;
                    else
                        cnt_ff <= cnt_ff + 16'h0001;
                end
                D_RUN:
                begin
                    cnt_ff <= 16'h0000;
                    if (en_ff && !rst_sy_ff[1])
                        st_ff <= D_RESET;
                    else if (take && link.cmd_idx == `MFRT_CMD_RESET)
                        st_ff <= D_INIT;
                end
            endcase
        end
    end

    // every command is echoed so the host never hangs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_ff <= 1'b0;
            vld_ff <= 1'b0;
            idx_ff <= 6'h00;
            arg_ff <= 32'h00000000;
        end
        else
        begin
            vld_ff <= take;
            if (new_cmd)
                ack_ff <= tgl_sy_ff[1];
            if (take)
            begin
                idx_ff <= link.cmd_idx;
                arg_ff <= link.cmd_arg;
            end
        end
    end

    // opcond triggers an internal raw array read
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_ff  <= 1'b0;
            rdc_ff <= 32'h00000000;
        end
        else
        begin
            rd_ff <= take && (link.cmd_idx == `MFRT_CMD_OPCOND); // R8
            if (take && link.cmd_idx == `MFRT_CMD_OPCOND && rdc_ff != 32'hFFFFFFFF)
                rdc_ff <= rdc_ff + 32'h00000001; // R8
        end
    end

    // partition set changes the limit; host must re-read it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            lim_ff <= `MFRT_PRELOAD_DEF;
        else if (take && link.cmd_idx == `MFRT_CMD_SWITCH)
            lim_ff <= enh_limit; // R6
    end

    // preload grant never exceeds the limit
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            grant_ff <= 32'h00000000;
            done_ff  <= 1'b0;
            cap_ff   <= 1'b0;
        end
        else
        begin
            done_ff <= pre_req;
            if (pre_req)
            begin
                grant_ff <= (pre_len > lim_ff) ? lim_ff : pre_len; // R5
                cap_ff   <= (pre_len > lim_ff); // R5
            end
        end
    end

    // bus clock edges counted since the last reset release
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pre_ff <= 7'h00;
        else if (!rst_sy_ff[1])
            pre_ff <= 7'h00;
        else if (clk_sy_ff[1] && !clk_sy_ff[2] && pre_ff != 7'(`MFRT_PREAMBLE_CYC))
            pre_ff <= pre_ff + 7'h01;
    end

    assign link.ack_tgl = ack_ff;
    assign cmd_valid    = vld_ff;
    assign cmd_index    = idx_ff;
    assign cmd_arg      = arg_ff;
    assign nand_read    = rd_ff;
    assign read_count   = rdc_ff;
    assign pre_limit    = lim_ff;
    assign pre_grant    = grant_ff;
    assign pre_done     = done_ff;
    assign pre_capped   = cap_ff;
    assign dev_ready    = (st_ff == D_RUN);
    assign preamble_ok  = (pre_ff == 7'(`MFRT_PREAMBLE_CYC));
endmodule : mfrt_dev
`default_nettype wire

//--- bench/mfrt_monitor.sv
// Purpose: link-side checks between host and device ends
// Assumes: one clock domain, counts at 100 MHz
// Notes:   saturating counters keep long waits cheap
`default_nettype none
module mfrt_monitor #(
    parameter int unsigned RST_CMD_CYC = 200
) (
    input wire logic        clk,       // core clock
    input wire logic        arst_n,    // async reset
    input wire logic        rst_n_pin, // reset pin
    input wire logic        clk_pin,   // bus clock
    input wire logic        cmd_tgl,   // command toggle
    input wire logic [5:0]  cmd_idx,   // command index
    input wire logic [31:0] cmd_arg,   // command argument
    input wire logic        ack_tgl    // device echo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] low_cnt_ff;
    logic [15:0] high_cnt_ff;
    logic [7:0]  rise_cnt_ff;
    logic        clk_pin_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // cycles the pin has stood low, saturating
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n) low_cnt_ff <= 16'h0000;
        else if (rst_n_pin) low_cnt_ff <= 16'h0000;
        else if (low_cnt_ff != 16'hFFFF) low_cnt_ff <= low_cnt_ff + 16'h0001;
    end
    // cycles the pin has stood high, saturating
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n) high_cnt_ff <= 16'h0000;
        else if (!rst_n_pin) high_cnt_ff <= 16'h0000;
        else if (high_cnt_ff != 16'hFFFF) high_cnt_ff <= high_cnt_ff + 16'h0001;
    end
    // bus clock rises since the pin went high
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n) clk_pin_ff <= 1'b0;
        else clk_pin_ff <= clk_pin;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n) rise_cnt_ff <= 8'h00;
        else if (!rst_n_pin) rise_cnt_ff <= 8'h00;
        else if (clk_pin && !clk_pin_ff && rise_cnt_ff != 8'hFF)
            rise_cnt_ff <= rise_cnt_ff + 8'h01;
    end
    sequence s_ack_back;
        ##[1:8] (ack_tgl == cmd_tgl);
    endsequence
    sequence s_half_high;
        clk_pin [*6] ##1 !clk_pin;
    endsequence
    a_rst_low_width: assert property ($rose(rst_n_pin) |-> low_cnt_ff >= 16'h0064)
        else $error("reset pulse shorter than 100 cycles");
    a_rst_high_gap: assert property ($fell(rst_n_pin) |-> high_cnt_ff >= 16'h0064)
        else $error("reset interval shorter than 100 cycles");
    a_first_cmd_wait: assert property ($changed(cmd_tgl) |-> high_cnt_ff >= RST_CMD_CYC)
        else $error("command too soon after reset release");
    a_pin_low_quiet: assert property (!rst_n_pin |-> $stable(cmd_tgl))
        else $error("command sent while reset pin low");
    a_preamble_count: assert property ($changed(cmd_tgl) && (cmd_idx == 6'h01
        || (cmd_idx == 6'h00 && cmd_arg == 32'h0FFFFFFA)) |-> rise_cnt_ff >= 8'h4A)
        else $error("init command before 74 bus clocks");
    a_ack_echo: assert property ($changed(cmd_tgl) |-> s_ack_back)
        else $error("device ack did not return");
    a_words_held: assert property (ack_tgl != cmd_tgl && !$changed(cmd_tgl)
        |-> $stable(cmd_idx) && $stable(cmd_arg))
        else $error("command words moved before ack");
    a_bus_clk_half: assert property ($rose(clk_pin) |-> s_half_high)
        else $error("bus clock high phase not 6 cycles");
endmodule : mfrt_monitor
`default_nettype wire

//--- bench/managed_flash_reset_timing_test.sv
// Purpose: drives host and device ends against a small reference model
// Assumes: short reset-to-command wait and query gap via parameters
// Notes:   device enters init after each CMD0, so sends are spaced
`include "mfrt_defs.svh"
`default_nettype none
module managed_flash_reset_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, rst_req, cmd_req, rst_pin_en, pre_req;
    logic [5:0]  h_idx, d_idx;
    logic [31:0] h_arg, d_arg, enh_limit, pre_len, pre_grant, pre_limit, read_count;
    logic cmd_ready, cmd_sent, cmd_refused, rst_refused, link_up;
    logic pre_done, pre_capped, cmd_valid, nand_read, dev_ready, preamble_ok;
    logic [31:0] exp_rd, exp_lim;
    int num_errors, checks, init_cnt;
    mfrt_link_if link ();
    mfrt_host #(.RST_CMD_CYC(200), .WP_GAP_CYC(20)) i_mfrt_host (.clk(clk), .arst_n(arst_n),
        .link(link), .rst_req(rst_req), .cmd_req(cmd_req), .cmd_idx(h_idx), .cmd_arg(h_arg),
        .cmd_ready(cmd_ready), .cmd_sent(cmd_sent), .cmd_refused(cmd_refused),
        .rst_refused(rst_refused), .link_up(link_up));
    mfrt_dev i_mfrt_dev (.clk(clk), .arst_n(arst_n), .link(link), .rst_pin_en(rst_pin_en),
        .enh_limit(enh_limit), .pre_req(pre_req), .pre_len(pre_len), .pre_grant(pre_grant),
        .pre_done(pre_done), .pre_capped(pre_capped), .pre_limit(pre_limit),
        .cmd_valid(cmd_valid), .cmd_index(d_idx), .cmd_arg(d_arg), .nand_read(nand_read),
        .read_count(read_count), .dev_ready(dev_ready), .preamble_ok(preamble_ok));
    mfrt_monitor #(.RST_CMD_CYC(200)) i_mfrt_monitor (.clk(clk), .arst_n(arst_n),
        .rst_n_pin(link.rst_n_pin), .clk_pin(link.clk_pin), .cmd_tgl(link.cmd_tgl),
        .cmd_idx(link.cmd_idx), .cmd_arg(link.cmd_arg), .ack_tgl(link.ack_tgl));
    // free-running core clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1
    task automatic finish_test;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    // bounded wait for the host to accept a command
    task automatic wait_ready;
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk1(cmd_ready, 1'b1);
        chk1(link_up, 1'b1);
    endtask : wait_ready
    // one command; model tracks raw reads, limit and init count
    task automatic send(input logic [5:0] i, input logic [31:0] a, input logic ok);
        int n;
        @(posedge clk);
        cmd_req <= 1'b1;
        h_idx   <= i;
        h_arg   <= a;
        @(posedge clk);
        cmd_req <= 1'b0;
        #1;
        chk1(cmd_sent, ok);
        chk1(cmd_refused, !ok);
        if (ok)
        begin
            n = 0;
            while (cmd_valid !== 1'b1 && n < 20)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            chk({25'h0, cmd_valid, d_idx}, {25'h0, 1'b1, i});
            chk(d_arg, a);
            chk1(nand_read, i == 6'h01);
            if (i == 6'h01) exp_rd = exp_rd + 32'h1;
            if (i == 6'h06) exp_lim = enh_limit;
            if (i <= 6'h01) init_cnt++;
            repeat (3) @(posedge clk);
            chk(read_count, exp_rd);
            chk(pre_limit, exp_lim);
            wait_ready();
        end
    endtask : send
    // preload request, grant is the smaller of request and limit
    task automatic pre(input logic [31:0] len);
        @(posedge clk);
        pre_req <= 1'b1;
        pre_len <= len;
        @(posedge clk);
        pre_req <= 1'b0;
        #1;
        chk1(pre_done, 1'b1);
        chk(pre_grant, (len > exp_lim) ? exp_lim : len);
        chk1(pre_capped, len > exp_lim);
    endtask : pre
    task automatic hw_reset(input logic refused);
        @(posedge clk);
        rst_req <= 1'b1;
        @(posedge clk);
        rst_req <= 1'b0;
        #1;
        chk1(rst_refused, refused);
    endtask : hw_reset
    // watchdog well beyond the few thousand cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    initial
    begin
        {arst_n, rst_req, cmd_req, pre_req} = 4'h0;
        rst_pin_en = 1'b1;
        h_idx = 6'h00;
        {h_arg, enh_limit, pre_len} = '0;
        exp_rd = 32'h0;
        exp_lim = `MFRT_PRELOAD_DEF;
        void'($urandom(52913));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        send(6'h01, 32'h0, 1'b0);
        $display("test early_command done");
        wait_ready();
        chk1(preamble_ok, 1'b0);
        send(6'h01, $urandom, 1'b0);
        repeat (900) @(posedge clk);
        chk1(preamble_ok, 1'b1);
        send(6'h01, $urandom, 1'b1);
        send(6'h01, $urandom, 1'b1);
        $display("test preamble_opcond done");
        send(6'h1E, $urandom, 1'b1);
        send(6'h1F, $urandom, 1'b0);
        repeat (25) @(posedge clk);
        send(6'h1F, $urandom, 1'b1);
        $display("test query_spacing done");
        @(posedge clk);
        enh_limit <= $urandom_range(32'h00200000, 32'h00001000);
        pre(exp_lim - ($urandom % 16));
        pre(exp_lim + 32'h1 + ($urandom % 256));
        send(6'h06, $urandom, 1'b1);
        pre(exp_lim + 32'h1);
        $display("test preload_limit done");
        hw_reset(1'b0);
        init_cnt++;
        repeat (5) @(posedge clk);
        hw_reset(1'b1);
        repeat (20) @(posedge clk);
        chk1(dev_ready, 1'b0);
        chk1(link_up, 1'b0);
        wait_ready();
        chk1(dev_ready, 1'b1);
        $display("test hw_reset done");
        send(6'h00, 32'h0, 1'b1);
        repeat (40) @(posedge clk);
        send(6'h00, `MFRT_ARG_BOOT, 1'b0);
        while (init_cnt < `MFRT_INIT_MAX)
        begin
            send(6'h00, 32'h0, 1'b1);
            repeat (40) @(posedge clk);
        end
        send(6'h00, 32'h0, 1'b0);
        send(6'h01, 32'h0, 1'b0);
        $display("test init_repeat done");
        // second power-on with the pin disabled: device must run while pin is low
        @(posedge clk);
        rst_pin_en <= 1'b0;
        arst_n     <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (80) @(posedge clk);
        #1;
        chk1(dev_ready, 1'b1);
        chk1(link.rst_n_pin, 1'b0);
        chk(read_count, 32'h0);
        $display("test pin_disabled done");
        finish_test();
    end
endmodule : managed_flash_reset_timing_test
`default_nettype wire
